// >>> design/sfsp_port.sv
// serial flash slave port: framing, bit capture, output shifting, pause
// Functional notes
// RL1 - capture input bits on clock rise
// RL2 - shift output bits on clock fall
// RL3 - new sequence only on select fall
// RL4 - master holds select low whole sequence
// RL5 - work in modes 0 and 3
// RL6 - tolerate either idle clock level
// RL7 - decode 4K sectors and 32K blocks
// RL8 - pause suspends transfer, keeps state
// RL9 - protect pin gates lock bit effect
// RL10 - every unit is eight clock cycles
// RL11 - pause entry and exit at clock low
// RL12 - paused: output off, select resets
// RL13 - deselected: output off, partial bits dropped
`include "sfsp_defines.svh"
module sfsp_port (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        din,
  input  wire logic        pause_n,
  input  wire logic        wprot_n,
  input  wire logic        dout_oe_n_req,
  output logic             dout,
  output logic             dout_oe_n,
  input  wire logic [7:0]  tx_byte,
  output logic             tx_take,
  input  wire logic        protect_lock_bit,
  output logic             lock_effective,
  output logic [7:0]       rx_byte,
  output logic             rx_valid,
  output logic             rx_is_op,
  output logic             cmd_start,
  output logic [23:0]      addr,
  output logic             addr_valid,
  output logic [11:0]      sector_idx,
  output logic [8:0]       block_idx,
  output logic             paused
);
  sfsp_sync_if sy ();
  sfsp_sync u_sync (
    .clock       (clock),
    .resetn      (resetn),
    .sck_pin     (sck),
    .sel_n_pin   (sel_n),
    .din_pin     (din),
    .pause_n_pin (pause_n),
    .wprot_n_pin (wprot_n),
    .sy          (sy)
  );

  sfsp_pkg::sfsp_state_t state_q, state_d;
  sfsp_pkg::sfsp_phase_t phase_q;
  logic [2:0]  bit_q;
  logic [6:0]  shin_q;
  logic [7:0]  shout_q;
  logic        out_q;
  logic [7:0]  rx_q;
  logic        rxv_q;
  logic        isop_q;
  logic        start_q;
  logic [1:0]  abytes_q;
  logic [23:0] addr_q;
  logic        addrv_q;
  logic        take_q;

  wire active  = (state_q == sfsp_pkg::SFSP_ACTIVE);
  wire sck_low = ~sy.sck;
  // pause enters and leaves only in a low clock phase; a pin change while
  // the clock is high waits here until the clock falls
  wire want_pause  = ~sy.pause_n & sck_low & ~sy.sel_n;
  wire want_resume = sy.pause_n & sck_low;
  // rises only count while active, so a mode 3 idle-high clock at select
  // fall never produces a spurious bit
  wire bit_rise    = active & sy.sck_rise;
  wire bit_fall    = active & sy.sck_fall;
  wire unit_done   = bit_rise & (bit_q == `SFSP_BIT_LAST);
  wire [7:0] unit  = {shin_q, sy.din};

  // RL3 framing, RL8 RL11 RL12 pause
  always_comb begin
    state_d = state_q;
    case (state_q)
      sfsp_pkg::SFSP_IDLE: begin
        if (sy.sel_fall) state_d = sfsp_pkg::SFSP_ACTIVE;
      end
      sfsp_pkg::SFSP_ACTIVE: begin
        if (sy.sel_n) state_d = sfsp_pkg::SFSP_IDLE;
        else if (want_pause) state_d = sfsp_pkg::SFSP_PAUSE;
      end
      sfsp_pkg::SFSP_PAUSE: begin
        if (sy.sel_n) state_d = sfsp_pkg::SFSP_IDLE;
        else if (want_resume) state_d = sfsp_pkg::SFSP_ACTIVE;
      end
      default: state_d = sfsp_pkg::SFSP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) state_q <= sfsp_pkg::SFSP_IDLE;
    else state_q <= state_d;
  end

  // RL1 RL10 bit capture into eight-bit units
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_q  <= `SFSP_BIT_ZERO;
      shin_q <= 7'h00;
    end else if (state_q == sfsp_pkg::SFSP_IDLE) begin
      // RL13 drop partial bits
      bit_q  <= `SFSP_BIT_ZERO;
      shin_q <= 7'h00;
    end else if (bit_rise) begin
      bit_q  <= bit_q + 3'h1;
      shin_q <= unit[6:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_q    <= 8'h00;
      rxv_q   <= 1'b0;
      isop_q  <= 1'b0;
      phase_q <= sfsp_pkg::SFSP_PH_OP;
      start_q <= 1'b0;
    end else begin
      rxv_q   <= unit_done;
      start_q <= sy.sel_fall & (state_q == sfsp_pkg::SFSP_IDLE);
      if (state_q == sfsp_pkg::SFSP_IDLE) begin
        phase_q <= sfsp_pkg::SFSP_PH_OP;
      end else if (unit_done) begin
        rx_q   <= unit;
        isop_q <= (phase_q == sfsp_pkg::SFSP_PH_OP);
        if (phase_q == sfsp_pkg::SFSP_PH_OP)
          phase_q <= sfsp_pkg::SFSP_PH_ADDR;
        else if (phase_q == sfsp_pkg::SFSP_PH_ADDR &&
                 abytes_q == `SFSP_ADDR_BYTES - 2'h1)
          phase_q <= sfsp_pkg::SFSP_PH_DATA;
      end
    end
  end

  // address gathered msb byte first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      abytes_q <= 2'h0;
      addr_q   <= 24'h000000;
      addrv_q  <= 1'b0;
    end else if (state_q == sfsp_pkg::SFSP_IDLE) begin
      abytes_q <= 2'h0;
      addrv_q  <= 1'b0;
    end else if (unit_done && phase_q == sfsp_pkg::SFSP_PH_ADDR) begin
      abytes_q <= abytes_q + 2'h1;
      addr_q   <= {addr_q[15:0], unit};
      addrv_q  <= (abytes_q == `SFSP_ADDR_BYTES - 2'h1);
    end
  end

  // RL2 output shift on clock fall
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shout_q <= 8'h00;
      out_q   <= 1'b0;
      take_q  <= 1'b0;
    end else begin
      take_q <= 1'b0;
      if (bit_fall) begin
        if (bit_q == `SFSP_BIT_ZERO) begin
          out_q   <= tx_byte[7];
          shout_q <= {tx_byte[6:0], 1'b0};
          take_q  <= 1'b1;
        end else begin
          out_q   <= shout_q[7];
          shout_q <= {shout_q[6:0], 1'b0};
        end
      end
    end
  end

  assign dout      = out_q;
  // RL12 RL13 output released unless actively selected
  assign dout_oe_n = ~active | dout_oe_n_req;
  assign tx_take   = take_q;
  // RL9 lock bit counts only with protect pin low
  assign lock_effective = protect_lock_bit & ~sy.wprot_n;
  assign rx_byte    = rx_q;
  assign rx_valid   = rxv_q;
  assign rx_is_op   = isop_q;
  assign cmd_start  = start_q;
  assign addr       = addr_q;
  assign addr_valid = addrv_q;
  // RL7 sector and block decode
  assign sector_idx = addr_q[`SFSP_ADDR_W-1:`SFSP_SECTOR_LSB];
  assign block_idx  = addr_q[`SFSP_ADDR_W-1:`SFSP_BLOCK_LSB];
  assign paused     = (state_q == sfsp_pkg::SFSP_PAUSE);

  // RL1-RL3 RL6 RL8-RL13 checks: no capture outside active, output follows state
  AST_NO_BIT_IDLE: assert property (@(posedge clock) disable iff (!resetn)
    !active |=> $stable(bit_q) || bit_q == `SFSP_BIT_ZERO) // RL6
    else $error("bit counter moved while not active");
  AST_UNIT_EIGHT: assert property (@(posedge clock) disable iff (!resetn)
    unit_done |=> rx_valid && bit_q == `SFSP_BIT_ZERO) // RL10
    else $error("unit not closed after eight bits");
  AST_CAPTURE: assert property (@(posedge clock) disable iff (!resetn)
    unit_done |=> rx_byte[0] == $past(sy.din)) // RL1
    else $error("captured bit wrong");
  AST_SHIFT_FALL: assert property (@(posedge clock) disable iff (!resetn)
    !$past(bit_fall) && !$past(state_q == sfsp_pkg::SFSP_IDLE)
      |-> $stable(dout)) // RL2
    else $error("output changed without clock fall");
  AST_START: assert property (@(posedge clock) disable iff (!resetn)
    $rose(active) && $past(state_q) == sfsp_pkg::SFSP_IDLE
      |-> $past(sy.sel_fall)) // RL3
    else $error("sequence began without select fall");
  AST_PAUSE_ENTRY: assert property (@(posedge clock) disable iff (!resetn)
    $rose(paused) |-> $past(sck_low) && $past(!sy.pause_n)) // RL11
    else $error("pause entered with clock high");
  AST_PAUSE_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    paused |-> dout_oe_n && $stable(bit_q)) // RL8
    else $error("paused port drove or counted");
  // select seen high on two edges in a row
  sequence sfsp_desel_two_s;
    sy.sel_n ##1 sy.sel_n;
  endsequence
  AST_DESEL: assert property (@(posedge clock) disable iff (!resetn)
    sfsp_desel_two_s |-> dout_oe_n ##1 bit_q == `SFSP_BIT_ZERO) // RL13
    else $error("deselected port drove or kept bits");
  AST_PAUSE_RESET: assert property (@(posedge clock) disable iff (!resetn)
    paused && sy.sel_n |=> state_q == sfsp_pkg::SFSP_IDLE) // RL12
    else $error("select rise in pause did not reset");
  AST_LOCK: assert property (@(posedge clock) disable iff (!resetn)
    sy.wprot_n |-> !lock_effective) // RL9
    else $error("lock effective with protect pin high");
endmodule // sfsp_port

// >>> design/sfsp_defines.svh
// constants for the serial flash slave port
`ifndef SFSP_DEFINES_SVH
`define SFSP_DEFINES_SVH
`define SFSP_UNIT_BITS      4'h8
`define SFSP_BIT_LAST       3'h7
`define SFSP_BIT_ZERO       3'h0
`define SFSP_SECTOR_LSB     12
`define SFSP_BLOCK_LSB      15
`define SFSP_ADDR_W         24
`define SFSP_ADDR_BYTES     2'h3
`endif

// >>> design/sfsp_pkg.sv
// types for the serial flash slave port
package sfsp_pkg;
  typedef enum logic [1:0] {
    SFSP_IDLE   = 2'b00,
    SFSP_ACTIVE = 2'b01,
    SFSP_PAUSE  = 2'b10
  } sfsp_state_t;
  typedef enum logic [1:0] {
    SFSP_PH_OP   = 2'b00,
    SFSP_PH_ADDR = 2'b01,
    SFSP_PH_DATA = 2'b10
  } sfsp_phase_t;
endpackage

// >>> design/sfsp_sync_if.sv
// synchronised pin levels and edges shared between modules
interface sfsp_sync_if;
  logic sck;
  logic sck_rise;
  logic sck_fall;
  logic sel_n;
  logic sel_fall;
  logic din;
  logic pause_n;
  logic wprot_n;
  modport src (output sck, sck_rise, sck_fall, sel_n, sel_fall, din,
               pause_n, wprot_n);
  modport dst (input sck, sck_rise, sck_fall, sel_n, sel_fall, din,
               pause_n, wprot_n);
endinterface

// >>> design/sfsp_sync.sv
// two-flop input synchronisers with edge detection
module sfsp_sync (
  input  wire logic  clock,
  input  wire logic  resetn,
  input  wire logic  sck_pin,
  input  wire logic  sel_n_pin,
  input  wire logic  din_pin,
  input  wire logic  pause_n_pin,
  input  wire logic  wprot_n_pin,
  sfsp_sync_if.src   sy
);
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic       sck_old_q;
  logic       sel_old_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q    <= 5'h1b;
      sync_q    <= 5'h1b;
      // matches the reset level of the clock synchroniser, so no false
      // edge is seen right after reset
      sck_old_q <= 1'b1;
      sel_old_q <= 1'b1;
    end else begin
      meta_q    <= {wprot_n_pin, pause_n_pin, din_pin, sel_n_pin, sck_pin};
      sync_q    <= meta_q;
      sck_old_q <= sync_q[0];
      sel_old_q <= sync_q[1];
    end
  end

  assign sy.sck      = sync_q[0];
  assign sy.sel_n    = sync_q[1];
  assign sy.din      = sync_q[2];
  assign sy.pause_n  = sync_q[3];
  assign sy.wprot_n  = sync_q[4];
  assign sy.sck_rise = sync_q[0] & ~sck_old_q;
  assign sy.sck_fall = ~sync_q[0] & sck_old_q;
  assign sy.sel_fall = ~sync_q[1] & sel_old_q;
endmodule // sfsp_sync

// >>> tb/sfsp_master.sv
// spi bus master model driving the slave port pins
module sfsp_master (
  input  wire logic clock,
  input  wire logic dout,
  output logic      sck,
  output logic      sel_n,
  output logic      din,
  output logic      pause_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mode3;
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
    pause_n = 1'b1;
    mode3 = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck = m3;
    wait_clk(4);
    sel_n = 1'b0;
    wait_clk(4);
  endtask
  task automatic pause_step();
    pause_n = 1'b0;
    wait_clk(4);
    // clock and data wiggle while paused, ending low
    repeat (8) begin
      wait_clk(1);
      sck = ~sck;
      din = ~din;
    end
    pause_n = 1'b1;
    wait_clk(4);
  endtask
  task automatic hold_set(input logic v);
    pause_n = v;
    wait_clk(8);
  endtask
  task automatic unit(input logic [7:0] tx, input int nbits,
                      input int hold_at, output logic [7:0] rx);
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      if (i == hold_at) pause_step();
      din = tx[7 - i];
      wait_clk(4);
      sck = 1'b1;
      rx = {rx[6:0], dout};
      wait_clk(4);
    end
  endtask
  task automatic close_frame();
    wait_clk(4);
    sck = mode3;
    wait_clk(4);
    sel_n = 1'b1;
    // released line shows the inverse, not the last bit
    din = ~din;
    wait_clk(8);
  endtask
endmodule // sfsp_master

// >>> tb/sfsp_port_tb.sv
// self-checking bench for the serial flash slave port
module sfsp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic wprot_n = 1'b1;
  logic lock_bit = 1'b0;
  logic [7:0] tx_byte = 8'ha5;
  logic oe_req = 1'b0;
  logic sck, sel_n, din, pause_n, dout, dout_oe_n, tx_take, lock_eff;
  logic rx_valid, rx_is_op, cmd_start, addr_valid, paused;
  logic [7:0] rx_byte, got;
  logic [23:0] addr;
  logic [11:0] sector_idx;
  logic [8:0] block_idx;
  logic got_op;
  int n_start = 0, n_take = 0, cycles = 0, mismatches = 0, tests_run = 0;
  always #20 clock = ~clock;
  sfsp_master i_sfsp_master (.clock(clock), .dout(dout), .sck(sck),
    .sel_n(sel_n), .din(din), .pause_n(pause_n));
  sfsp_port i_sfsp_port (.clock(clock), .resetn(resetn), .sck(sck),
    .sel_n(sel_n), .din(din), .pause_n(pause_n), .wprot_n(wprot_n),
    .dout_oe_n_req(oe_req), .dout(dout), .dout_oe_n(dout_oe_n),
    .tx_byte(tx_byte), .tx_take(tx_take), .protect_lock_bit(lock_bit),
    .lock_effective(lock_eff), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_is_op(rx_is_op), .cmd_start(cmd_start), .addr(addr),
    .addr_valid(addr_valid), .sector_idx(sector_idx),
    .block_idx(block_idx), .paused(paused));
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
    if (cmd_start === 1'b1) n_start <= n_start + 1;
    if (tx_take === 1'b1) n_take <= n_take + 1;
    if (rx_valid === 1'b1) begin
      got <= rx_byte;
      got_op <= rx_is_op;
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic send(input logic [7:0] b, output logic [7:0] r);
    i_sfsp_master.unit(b, 8, -1, r);
    wait_n(4);
  endtask
  task automatic frame_test(input logic m3, input logic [7:0] tx);
    logic [7:0] r;
    int s;
    int t;
    s = n_start;
    t = n_take;
    tx_byte = tx;
    i_sfsp_master.open_frame(m3);
    chk(24'(n_start - s), 24'h1);
    send(8'h3b, r);
    chk(got, 8'h3b);
    chk(got_op, 1'b1);
    send(8'h12, r);
    chk(r, tx);
    chk(got_op, 1'b0);
    chk(dout_oe_n, 1'b0);
    oe_req = 1'b1;
    wait_n(1);
    chk(dout_oe_n, 1'b1);
    oe_req = 1'b0;
    send(8'h34, r);
    chk(r, tx);
    send(8'h56, r);
    chk(addr_valid, 1'b1);
    chk(addr, 24'h123456);
    chk(sector_idx, 12'h123);
    chk(block_idx, 9'h024);
    i_sfsp_master.close_frame();
    chk(dout_oe_n, 1'b1);
    chk(addr_valid, 1'b0);
    // four loads, one per fall at bit count zero: units 1-4 in mode 3, units 2-4 plus the closing fall in mode 0
    chk(24'(n_take - t), 24'h4);
  endtask
  task automatic partial_test();
    logic [7:0] r;
    i_sfsp_master.open_frame(1'b0);
    i_sfsp_master.unit(8'hff, 5, -1, r);
    i_sfsp_master.close_frame();
    i_sfsp_master.open_frame(1'b0);
    send(8'h81, r);
    chk(got, 8'h81);
    chk(got_op, 1'b1);
    i_sfsp_master.close_frame();
  endtask
  task automatic pause_test();
    logic [7:0] r;
    i_sfsp_master.open_frame(1'b1);
    fork
      i_sfsp_master.unit(8'hc6, 8, 3, r);
      begin
        wait (pause_n === 1'b0);
        wait_n(6);
        chk(paused, 1'b1);
        chk(dout_oe_n, 1'b1);
      end
    join
    wait_n(4);
    chk(got, 8'hc6);
    chk(paused, 1'b0);
    i_sfsp_master.close_frame();
    i_sfsp_master.open_frame(1'b0);
    i_sfsp_master.hold_set(1'b0);
    chk(paused, 1'b1);
    i_sfsp_master.close_frame();
    chk(paused, 1'b0);
    i_sfsp_master.hold_set(1'b1);
    chk(paused, 1'b0);
    i_sfsp_master.open_frame(1'b0);
    send(8'h42, r);
    chk(got_op, 1'b1);
    i_sfsp_master.close_frame();
  endtask
  task automatic lock_test();
    for (int i = 0; i < 4; i++) begin
      wprot_n = i[1];
      lock_bit = i[0];
      wait_n(4);
      chk(lock_eff, i == 1);
    end
  endtask
  initial begin
    wait_n(16);
    chk(dout_oe_n, 1'b1);
    resetn = 1'b1;
    wait_n(4);
    frame_test(1'b0, 8'ha5);
    frame_test(1'b1, 8'h5a);
    partial_test();
    pause_test();
    lock_test();
    complete_run();
  end
endmodule // sfsp_port_tb
